//--- testbench/tmq_user_model.sv
// Behavioural model of the user logical layer ports and management port.
`timescale 1ns/1ps
module tmq_user_model #(
	parameter int LEN = 3
) (
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [4:0]       go_i,
	input  wire logic [4:0][1:0]  pri_i,
	input  wire logic [4:0]       tx_ready_i,
	output logic      [4:0]       tx_valid_o,
	output logic      [4:0]       tx_sop_o,
	output logic      [4:0]       tx_eop_o,
	output logic      [4:0][63:0] tx_data_o
);
	logic [4:0]      busy_reg;
	logic [4:0][7:0] beat_reg;
	logic [4:0][1:0] pri_reg;

	for (genvar p = 0; p < 5; p++) begin : g_port
		// Each port holds one packet and moves a beat only when the core takes it.
		always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				busy_reg[p] <= 1'b0;
				beat_reg[p] <= 8'h00;
				pri_reg[p]  <= 2'h0;
			end else if (go_i[p] && !busy_reg[p]) begin
				busy_reg[p] <= 1'b1;
				beat_reg[p] <= 8'h00;
				pri_reg[p]  <= pri_i[p];
			end else if (busy_reg[p] && tx_ready_i[p]) begin
				busy_reg[p] <= (beat_reg[p] != 8'(LEN - 1));
				beat_reg[p] <= beat_reg[p] + 8'h01;
			end
		end
		// Priority sits in the two top bits; an idle port shows inverted data so stale
		// values are never mistaken for a live beat.
		assign tx_valid_o[p] = busy_reg[p];
		assign tx_sop_o[p]   = busy_reg[p] && (beat_reg[p] == 8'h00);
		assign tx_eop_o[p]   = busy_reg[p] && (beat_reg[p] == 8'(LEN - 1));
		assign tx_data_o[p]  = busy_reg[p] ? {pri_reg[p], 56'(beat_reg[p]), 3'(p), 3'h0}
			: ~{pri_reg[p], 56'(beat_reg[p]), 3'(p), 3'h0};
	end
endmodule

//--- testbench/tx_mux_arbiter_and_queue_bench.sv
// Self-checking bench for the transmit multiplexer and queuing unit.
`timescale 1ns/1ps
module tx_mux_arbiter_and_queue_bench;
	typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} tmq_row_s;
	logic             clk, rst, retry;
	logic             lrdy = 1'b0;
	logic [3:0]       avs_address;
	logic             avs_read, avs_write;
	logic [31:0]      avs_writedata, avs_readdata, q;
	logic             avs_waitrequest;
	logic [4:0]       go, tx_valid, tx_sop, tx_eop, tx_ready;
	logic [4:0]       tx_valid2, tx_sop2, tx_eop2, tx_ready2;
	logic [4:0][1:0]  pri;
	logic [4:0][63:0] tx_data;
	logic [4:0][63:0] tx_data2;
	logic             link_valid, link_sop, link_eop;
	logic [63:0]      link_data;
	logic [19:0]      depth;
	logic [3:0]       fc_state;
	logic [2:0]       gq[$], lq[$], rq[$];
	logic [2:0]       order[5] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3};
	int               fail_count = 0;
	int               n_checks = 0;
	tmq_row_s         rows[10] = '{
		'{1'b0, 4'h0, 32'h0, 32'h0}, '{1'b0, 4'h4, 32'h0, 32'hf},
		'{1'b0, 4'h8, 32'h0, 32'h0}, '{1'b0, 4'hc, 32'h0, 32'h0},
		'{1'b1, 4'h0, 32'h3, 32'h0}, '{1'b0, 4'h0, 32'h0, 32'h3},
		'{1'b1, 4'h4, 32'h5, 32'h0}, '{1'b0, 4'h4, 32'h0, 32'h5},
		'{1'b1, 4'hc, 32'hff, 32'h0}, '{1'b0, 4'hc, 32'h0, 32'h0}};

	tmq_top #(.ROTATE(1'b0)) dut (.sys_clk_i(clk), .sys_rst_i(rst),
		.avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(4'h1),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.tx_valid_i(tx_valid), .tx_sop_i(tx_sop), .tx_eop_i(tx_eop), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready), .link_valid_o(link_valid), .link_ready_i(lrdy),
		.link_sop_o(link_sop), .link_eop_o(link_eop), .link_data_o(link_data),
		.link_retry_i(retry), .tx_flow_depth_o(depth), .tx_flow_ctrl_state_o(fc_state));

	tmq_user_model #(.LEN(3)) user (.sys_clk_i(clk), .sys_rst_i(rst), .go_i(go),
		.pri_i(pri), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_sop_o(tx_sop),
		.tx_eop_o(tx_eop), .tx_data_o(tx_data));

	// A rotating copy sees the same offers; only its grant order is watched.
	tmq_top #(.ROTATE(1'b1)) dut_rot (.sys_clk_i(clk), .sys_rst_i(rst),
		.avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(4'h1), .avs_readdata_o(),
		.avs_waitrequest_o(), .tx_valid_i(tx_valid2), .tx_sop_i(tx_sop2),
		.tx_eop_i(tx_eop2), .tx_data_i(tx_data2), .tx_ready_o(tx_ready2),
		.link_valid_o(), .link_ready_i(lrdy), .link_sop_o(), .link_eop_o(),
		.link_data_o(), .link_retry_i(retry), .tx_flow_depth_o(),
		.tx_flow_ctrl_state_o());

	tmq_user_model #(.LEN(3)) user_rot (.sys_clk_i(clk), .sys_rst_i(rst), .go_i(go),
		.pri_i(pri), .tx_ready_i(tx_ready2), .tx_valid_o(tx_valid2), .tx_sop_o(tx_sop2),
		.tx_eop_o(tx_eop2), .tx_data_o(tx_data2));

	// Free-running core clock at 125 MHz.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// The link stalls every other cycle so each beat must be held.
	always @(posedge clk) begin
		lrdy <= ~lrdy;
	end

	// Monitors sample at the falling edge, where combinational outputs have settled.
	always @(negedge clk) begin
		for (int p = 0; p < 5; p++) begin
			if (tx_ready[p] && tx_valid[p] && tx_sop[p]) gq.push_back(3'(p));
			if (tx_ready2[p] && tx_valid2[p] && tx_sop2[p]) rq.push_back(3'(p));
		end
		if (link_valid && lrdy && link_sop) lq.push_back(link_data[5:3]);
		if (!$onehot0(tx_ready)) chk("single grant", 32'h0, 32'h1);
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One Avalon access; the request is held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Let the completing edge settle so callers see the register's new value.
		@(negedge clk);
		if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
	endtask

	task automatic offer(input logic [4:0] m, input logic [4:0][1:0] p);
		@(posedge clk);
		go <= m;
		pri <= p;
		@(posedge clk);
		go <= 5'h00;
	endtask

	// Waits with a bound for the total queue depth to reach a value.
	task automatic wait_tot(input int t);
		int n;
		n = 0;
		while (depth[19:16] !== 4'(t) && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk("total depth", 32'(t), 32'(depth[19:16]));
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a tenth of this span.
	initial begin
		#400000;
		fail_count++;
		give_verdict();
	end

	// Main sequence: register rows first, then arbitration, full pool and flow control.
	initial begin
		rst = 1'b1;
		retry = 1'b0;
		go = 5'h00;
		pri = '0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("register read", rows[i].e, q);
		end
		bus(1'b1, 4'h4, 32'hf);
		bus(1'b1, 4'h0, 32'h2);
		// Five ports offer at once; the winners must go by level, then by port number.
		offer(5'h1f, {2'd3, 2'd0, 2'd3, 2'd3, 2'd1});
		wait_tot(5);
		foreach (order[i]) chk("grant order", 32'(order[i]), 32'(gq[i]));
		foreach (order[i]) chk("rotating order", 32'(order[i]), 32'(rq[i]));
		chk("queue depths", 32'h53011, 32'(depth));
		bus(1'b1, 4'h0, 32'h0);
		wait_tot(0);
		foreach (order[i]) chk("link order", 32'(order[i]), 32'(lq[i]));
		// Ports 0 and 3 tie at level 1; that level's index now names port 1, so 3 wins in the rotating copy, 0 in the fixed one.
		bus(1'b1, 4'h0, 32'h2);
		offer(5'h09, {2'd0, 2'd1, 2'd0, 2'd0, 2'd1});
		wait_tot(2);
		chk("fixed tie", 32'h0, 32'(gq[5]));
		chk("rotating tie", 32'h3, 32'(rq[5]));
		bus(1'b1, 4'h0, 32'h0);
		wait_tot(0);
		// Fill every slot; the fifteenth offer must wait until a slot is freed.
		lq.delete();
		bus(1'b1, 4'h0, 32'h2);
		for (int i = 0; i < 14; i++) begin
			offer(5'(1 << (i % 4)), '0);
			wait_tot(i + 1);
		end
		offer(5'h10, '0);
		repeat (40) @(negedge clk);
		chk("refused grant", 32'h0, 32'(tx_ready[4]));
		chk("full depth", 32'he, 32'(depth[19:16]));
		bus(1'b1, 4'h0, 32'h0);
		repeat (200) @(negedge clk);
		wait_tot(0);
		chk("drained count", 32'd15, 32'(lq.size()));
		// Far end has room only at level 0, so the level 3 packet must wait.
		lq.delete();
		bus(1'b1, 4'h0, 32'h3);
		bus(1'b1, 4'h4, 32'h1);
		chk("flow state", 32'h1, 32'(fc_state));
		offer(5'h03, {2'd0, 2'd0, 2'd0, 2'd0, 2'd3});
		wait_tot(2);
		bus(1'b1, 4'h0, 32'h1);
		wait_tot(1);
		repeat (60) @(negedge clk);
		chk("blocked level", 32'h11000, 32'(depth));
		chk("unblocked first", 32'h1, 32'(lq[0]));
		bus(1'b1, 4'h4, 32'hf);
		wait_tot(0);
		chk("released second", 32'h0, 32'(lq[1]));
		// A retry while the packet is on the link must resend it from its first beat.
		lq.delete();
		offer(5'h04, {5{2'd2}});
		for (int i = 0; i < 200 && !(link_valid && link_sop); i++) @(negedge clk);
		@(posedge clk);
		retry <= 1'b1;
		@(posedge clk);
		retry <= 1'b0;
		wait_tot(0);
		chk("retry resend", 32'h2, 32'(lq.size()));
		chk("resent port", 32'h2, 32'(lq[1]));
		// Reset in mid-run empties the queues and restores the flow state.
		bus(1'b1, 4'h0, 32'h2);
		bus(1'b1, 4'h4, 32'h3);
		offer(5'h04, '0);
		wait_tot(1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("reset depth", 32'h0, 32'(depth));
		chk("reset flow state", 32'hf, 32'(fc_state));
		chk("reset ready", 32'h0, 32'(tx_ready));
		give_verdict();
	end
endmodule

//--- verilog/tmq_arb.sv
// Two-phase arbiter: packet priority first, then fixed or rotating port priority.
`timescale 1ns/1ps
`include "tmq_consts.svh"
module tmq_arb #(
	parameter bit ROTATE = 1'b0
) (
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	tmq_arb_if.arb    ab
);
	logic [3:0][2:0] idx_reg;
	logic [3:0]      pos;
	logic [2:0]      base;
	logic            higher_seen;
	logic            lower_tied;

	// Winning level is the highest offered; ports tied there are then scanned in order.
	always_comb begin
		ab.win_pri     = 2'h0;
		ab.grant_valid = 1'b0;
		ab.grant_port  = 3'h0;
		pos            = 4'h0;
		for (int i = 0; i < `TMQ_NPORT; i++) begin
			if (ab.req[i] && ab.pri[i] > ab.win_pri) begin // R5 R6
				ab.win_pri = ab.pri[i];
			end
		end
		base = ROTATE ? idx_reg[ab.win_pri] : 3'h0; // R8 R9 R10
		for (int k = `TMQ_NPORT - 1; k >= 0; k--) begin
			pos = 4'(base) + 4'(k);
			if (pos >= 4'(`TMQ_NPORT)) begin // R21
				pos = pos - 4'(`TMQ_NPORT);
			end
			if (ab.req[pos[2:0]] && ab.pri[pos[2:0]] == ab.win_pri) begin // R3 R7
				ab.grant_valid = 1'b1;
				ab.grant_port  = pos[2:0];
			end
		end
	end

	// Only the contest at a level moves that level's index, so levels rotate independently.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			idx_reg <= '0;
		end else if (ab.start && ab.grant_valid) begin
			idx_reg[ab.win_pri] <= (ab.grant_port == `TMQ_MGMT_PORT) ? 3'h0 :
				ab.grant_port + 3'h1; // R10 R11 R21
		end
	end

	// Checker helpers: a request above the winner, or a tied port ahead of it in fixed order.
	always_comb begin
		higher_seen = 1'b0;
		lower_tied  = 1'b0;
		for (int i = 0; i < `TMQ_NPORT; i++) begin
			if (ab.req[i] && ab.pri[i] > ab.pri[ab.grant_port]) begin
				higher_seen = 1'b1;
			end
			if (ab.req[i] && ab.pri[i] == ab.win_pri && 3'(i) < ab.grant_port) begin
				lower_tied = 1'b1;
			end
		end
	end

	a_grant_is_top: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R6
		ab.grant_valid |-> ab.req[ab.grant_port] && !higher_seen)
		else $error("grant went to a port below the winning priority");
	a_fixed_order: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R9
		(!ROTATE && ab.grant_valid) |-> !lower_tied)
		else $error("fixed scheme skipped a higher port");
	a_rot_index: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R10
		(ROTATE && ab.start && ab.grant_valid && ab.grant_port != `TMQ_MGMT_PORT) |=>
		idx_reg[$past(ab.win_pri)] == $past(ab.grant_port) + 3'h1)
		else $error("priority index not winner plus one");
	a_rot_wrap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R21
		(ab.start && ab.grant_valid && ab.grant_port == `TMQ_MGMT_PORT) |=>
		idx_reg[$past(ab.win_pri)] == 3'h0)
		else $error("priority index did not wrap after management");
	a_idx_other: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R11
		(ab.start && ab.grant_valid) |=>
		idx_reg[$past(ab.win_pri) + 2'h1] == $past(idx_reg[ab.win_pri + 2'h1]))
		else $error("index of another level moved");
endmodule

//--- verilog/tmq_arb_if.sv
// Request and grant signals between the queuing unit and the port arbiter.
`timescale 1ns/1ps
interface tmq_arb_if;
	logic [4:0]                    req;
	tmq_pkg::tmq_pri_t [4:0]       pri;
	logic                          start;
	logic                          grant_valid;
	tmq_pkg::tmq_port_t            grant_port;
	tmq_pkg::tmq_pri_t             win_pri;

	modport arb (input req, input pri, input start,
		output grant_valid, output grant_port, output win_pri);
	modport mux (output req, output pri, output start,
		input grant_valid, input grant_port, input win_pri);
endinterface

//--- verilog/tmq_consts.svh
// Constants for the transmit multiplexer, arbiter and queuing unit.
// How it works
// R1: Pick next enqueue packet from offered ports.
// R2: Stall other ports while one packet enqueues.
// R3: Arbitrate by packet priority, then port.
// R4: Packet priority is top two data bits.
// R5: Strict priority order, level 3 highest.
// R6: Highest offered level wins; sole owner enqueues.
// R7: Ties at winning level use port priority.
// R8: Fixed or rotating scheme, build-time choice.
// R9: Fixed: port 0 highest, management lowest.
// R10: Rotating index becomes winner plus one.
// R11: One rotating index per priority level.
// R12: 4096-byte buffer split into 14 280-byte slots.
// R13: Four queues share all fourteen slots.
// R14: User leaves one slot for management responses; the core reserves none, so user ports can fill all 14 slots.
// R15: Output per-queue and total occupancy.
// R16: Output transmit flow control state.
// R17: Queue chosen from first beat's priority bits.
// R18: Refuse new packet while all slots full.
// R19: Dequeue honours priority, flow control, retransmission.
// R20: Packet leaves only after fully stored.
// R21: Rotation order 0,1,2,3, management, wrap.
// R22: Dequeue oldest of highest non-empty queue.
`ifndef TMQ_CONSTS_SVH
`define TMQ_CONSTS_SVH

`define TMQ_NPORT       5
`define TMQ_MGMT_PORT   3'h4
`define TMQ_SLOT_BYTES  16'h0118
`define TMQ_BUF_BYTES   16'h1000
`define TMQ_BEAT_BYTES  16'h0008
`define TMQ_NSLOT       (4'(`TMQ_BUF_BYTES / `TMQ_SLOT_BYTES))
`define TMQ_SLOT_BEATS  (6'(`TMQ_SLOT_BYTES / `TMQ_BEAT_BYTES))
`define TMQ_MEM_WORDS   (`TMQ_BUF_BYTES / `TMQ_BEAT_BYTES)
`define TMQ_PRI_HI      63
`define TMQ_PRI_LO      62

`define TMQ_REG_CTRL    4'h0
`define TMQ_REG_FCST    4'h4
`define TMQ_REG_DEPTH   4'h8
`define TMQ_CTRL_FC_EN  0
`define TMQ_CTRL_HOLD   1
`define TMQ_CTRL_RST    2'h0
`define TMQ_FCST_RST    4'hf

`endif

//--- verilog/tmq_pkg.sv
// Types shared by the transmit multiplexer and queuing unit.
package tmq_pkg;
	typedef logic [1:0] tmq_pri_t;
	typedef logic [2:0] tmq_port_t;
	typedef logic [3:0] tmq_slot_t;
	typedef enum logic [0:0] {TMQ_ENQ_IDLE, TMQ_ENQ_WRITE} tmq_enq_e;
	typedef enum logic [0:0] {TMQ_DQ_IDLE, TMQ_DQ_SEND} tmq_dq_e;
endpackage

//--- verilog/tmq_top.sv
// Transmit multiplexer and queuing unit with an Avalon-MM control slave.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tmq_consts.svh"
module tmq_top #(
	parameter bit ROTATE = 1'b0
) (
	input  wire logic                sys_clk_i,
	input  wire logic                sys_rst_i,
	input  wire logic [3:0]          avs_address_i,
	input  wire logic                avs_read_i,
	input  wire logic                avs_write_i,
	input  wire logic [31:0]         avs_writedata_i,
	input  wire logic [3:0]          avs_byteenable_i,
	output logic      [31:0]         avs_readdata_o,
	output logic                     avs_waitrequest_o,
	input  wire logic [4:0]          tx_valid_i,
	input  wire logic [4:0]          tx_sop_i,
	input  wire logic [4:0]          tx_eop_i,
	input  wire logic [4:0][63:0]    tx_data_i,
	output logic      [4:0]          tx_ready_o,
	output logic                     link_valid_o,
	input  wire logic                link_ready_i,
	output logic                     link_sop_o,
	output logic                     link_eop_o,
	output logic      [63:0]         link_data_o,
	input  wire logic                link_retry_i,
	output logic      [19:0]         tx_flow_depth_o,
	output logic      [3:0]          tx_flow_ctrl_state_o
);
	tmq_arb_if ab ();

	tmq_pkg::tmq_enq_e   enq_state_reg;
	tmq_pkg::tmq_port_t  grant_reg;
	tmq_pkg::tmq_slot_t  wr_slot_reg;
	logic [5:0]          wr_beat_reg;
	tmq_pkg::tmq_pri_t   wr_pri_reg;
	logic [13:0]         free_reg;
	tmq_pkg::tmq_slot_t  free_slot;
	logic                free_any;
	logic                beat_take;
	logic                push_v;
	tmq_pkg::tmq_pri_t   push_pri;
	logic [63:0]         mem [0:`TMQ_MEM_WORDS-1];
	logic [5:0]          len_reg [0:13];

	tmq_pkg::tmq_dq_e    dq_state_reg;
	tmq_pkg::tmq_pri_t   dq_pri_reg;
	tmq_pkg::tmq_slot_t  dq_slot_reg;
	logic [5:0]          rd_beat_reg;
	logic [3:0][3:0]     cnt_w;
	logic [3:0][3:0]     head_w;
	logic [3:0]          elig;
	logic                dq_any;
	tmq_pkg::tmq_pri_t   dq_pick;
	logic                pop_v;
	logic                out_load;
	logic [3:0]          total_reg;

	logic [1:0]          ctrl_reg;
	logic [3:0]          fcst_reg;
	logic                ack_reg;

	// Arbiter sees every offered packet; its priority rides in the top data bits.
	genvar gp;
	generate
		for (gp = 0; gp < `TMQ_NPORT; gp++) begin : g_port
			assign ab.pri[gp] = tx_data_i[gp][`TMQ_PRI_HI:`TMQ_PRI_LO]; // R4
			assign tx_ready_o[gp] = (enq_state_reg == tmq_pkg::TMQ_ENQ_WRITE) &&
				(grant_reg == 3'(gp)); // R2
		end
	endgenerate
	assign ab.req   = tx_valid_i & tx_sop_i; // R1
	assign ab.start = (enq_state_reg == tmq_pkg::TMQ_ENQ_IDLE) && free_any; // R18

	tmq_arb #(
		.ROTATE (ROTATE)
	) u_arb (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.ab        (ab)
	);

	// Lowest free slot is handed to the next packet.
	always_comb begin
		free_slot = 4'h0;
		for (int s = 13; s >= 0; s--) begin
			if (free_reg[s]) begin
				free_slot = 4'(s);
			end
		end
	end
	assign free_any  = |free_reg; // R12
	assign beat_take = tx_valid_i[grant_reg] && tx_ready_o[grant_reg];
	assign push_v    = beat_take && tx_eop_i[grant_reg];
	assign push_pri  = (wr_beat_reg == 6'h0) ?
		tx_data_i[grant_reg][`TMQ_PRI_HI:`TMQ_PRI_LO] : wr_pri_reg; // R17

	// Enqueue sequencer: one packet at a time, granted port holds the path until its last beat.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			enq_state_reg <= tmq_pkg::TMQ_ENQ_IDLE;
			grant_reg     <= 3'h0;
			wr_slot_reg   <= 4'h0;
			wr_beat_reg   <= 6'h0;
			wr_pri_reg    <= 2'h0;
		end else begin
			case (enq_state_reg)
				tmq_pkg::TMQ_ENQ_IDLE: begin
					if (ab.start && ab.grant_valid) begin // R1 R18
						enq_state_reg <= tmq_pkg::TMQ_ENQ_WRITE;
						grant_reg     <= ab.grant_port;
						wr_slot_reg   <= free_slot;
						wr_beat_reg   <= 6'h0;
					end
				end
				tmq_pkg::TMQ_ENQ_WRITE: begin
					if (beat_take) begin
						if (wr_beat_reg == 6'h0) begin
							wr_pri_reg <= push_pri; // R17
						end
						if (wr_beat_reg != `TMQ_SLOT_BEATS) begin
							wr_beat_reg <= wr_beat_reg + 6'h1;
						end
						if (tx_eop_i[grant_reg]) begin
							enq_state_reg <= tmq_pkg::TMQ_ENQ_IDLE;
						end
					end
				end
				default: begin
					enq_state_reg <= tmq_pkg::TMQ_ENQ_IDLE;
				end
			endcase
		end
	end

	// Packet store. Beats past a full slot are dropped rather than spilling into a neighbour.
	always_ff @(posedge sys_clk_i) begin
		if (beat_take && wr_beat_reg < `TMQ_SLOT_BEATS) begin
			mem[9'(wr_slot_reg) * 9'h023 + 9'(wr_beat_reg)] <= tx_data_i[grant_reg]; // R12
		end
		if (push_v) begin
			len_reg[wr_slot_reg] <= (wr_beat_reg < `TMQ_SLOT_BEATS) ?
				wr_beat_reg + 6'h1 : `TMQ_SLOT_BEATS;
		end
	end

	// Slot ownership: taken at grant, returned once the link has accepted the last beat.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			free_reg <= 14'h3fff;
		end else begin
			if (ab.start && ab.grant_valid) begin
				free_reg[free_slot] <= 1'b0;
			end
			if (pop_v) begin
				free_reg[dq_slot_reg] <= 1'b1;
			end
		end
	end

	// Four slot-index queues, one per priority level, each able to hold every slot.
	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_queue
			logic [3:0] q_mem [0:13];
			logic [3:0] head_reg;
			logic [3:0] tail_reg;
			logic [3:0] cnt_reg;
			logic       push_l;
			logic       pop_l;
			assign push_l = push_v && push_pri == 2'(gl); // R13
			assign pop_l  = pop_v && dq_pri_reg == 2'(gl);
			assign cnt_w[gl]  = cnt_reg;
			assign head_w[gl] = q_mem[head_reg];
			always_ff @(posedge sys_clk_i) begin
				if (push_l) begin
					q_mem[tail_reg] <= wr_slot_reg;
				end
			end
			always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					head_reg <= 4'h0;
					tail_reg <= 4'h0;
					cnt_reg  <= 4'h0;
				end else begin
					if (push_l) begin
						tail_reg <= (tail_reg == `TMQ_NSLOT - 4'h1) ? 4'h0 : tail_reg + 4'h1;
					end
					if (pop_l) begin
						head_reg <= (head_reg == `TMQ_NSLOT - 4'h1) ? 4'h0 : head_reg + 4'h1;
					end
					cnt_reg <= cnt_reg + 4'(push_l) - 4'(pop_l); // R13
				end
			end
		end
	endgenerate

	// Dequeue choice: a queue only counts once a whole packet sits in it, so no cut-through.
	always_comb begin
		dq_pick = 2'h0;
		dq_any  = 1'b0;
		for (int l = 0; l < 4; l++) begin
			elig[l] = cnt_w[l] != 4'h0 && // R20
				(!ctrl_reg[`TMQ_CTRL_FC_EN] || fcst_reg[l]); // R19
			if (elig[l]) begin
				dq_pick = 2'(l); // R22
				dq_any  = 1'b1;
			end
		end
	end

	assign out_load = (dq_state_reg == tmq_pkg::TMQ_DQ_SEND) && !link_retry_i &&
		(!link_valid_o || link_ready_i) && rd_beat_reg < len_reg[dq_slot_reg];
	assign pop_v = (dq_state_reg == tmq_pkg::TMQ_DQ_SEND) && !link_retry_i &&
		link_valid_o && link_ready_i && link_eop_o;

	// Dequeue sequencer. A retry rewinds the packet to its first beat; the slot stays held.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dq_state_reg <= tmq_pkg::TMQ_DQ_IDLE;
			dq_pri_reg   <= 2'h0;
			dq_slot_reg  <= 4'h0;
			rd_beat_reg  <= 6'h0;
			link_valid_o <= 1'b0;
			link_sop_o   <= 1'b0;
			link_eop_o   <= 1'b0;
		end else begin
			case (dq_state_reg)
				tmq_pkg::TMQ_DQ_IDLE: begin
					link_valid_o <= 1'b0;
					if (dq_any && !ctrl_reg[`TMQ_CTRL_HOLD]) begin // R19 R22
						dq_state_reg <= tmq_pkg::TMQ_DQ_SEND;
						dq_pri_reg   <= dq_pick;
						dq_slot_reg  <= head_w[dq_pick];
						rd_beat_reg  <= 6'h0;
					end
				end
				tmq_pkg::TMQ_DQ_SEND: begin
					if (link_retry_i) begin
						rd_beat_reg  <= 6'h0; // R19
						link_valid_o <= 1'b0;
					end else if (pop_v) begin
						dq_state_reg <= tmq_pkg::TMQ_DQ_IDLE;
						link_valid_o <= 1'b0;
					end else if (out_load) begin
						link_valid_o <= 1'b1;
						link_sop_o   <= rd_beat_reg == 6'h0;
						link_eop_o   <= rd_beat_reg + 6'h1 == len_reg[dq_slot_reg];
						rd_beat_reg  <= rd_beat_reg + 6'h1;
					end else if (link_ready_i) begin
						link_valid_o <= 1'b0;
					end
				end
				default: begin
					dq_state_reg <= tmq_pkg::TMQ_DQ_IDLE;
				end
			endcase
		end
	end

	// Read port of the store, registered so link data always comes from a flop.
	always_ff @(posedge sys_clk_i) begin
		if (out_load) begin
			link_data_o <= mem[9'(dq_slot_reg) * 9'h023 + 9'(rd_beat_reg)];
		end
	end

	// Occupancy report: four queue depths plus the running total.
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			total_reg <= 4'h0;
		end else begin
			total_reg <= total_reg + 4'(push_v) - 4'(pop_v); // R15
		end
	end
	assign tx_flow_depth_o      = {total_reg, cnt_w}; // R15
	assign tx_flow_ctrl_state_o = fcst_reg; // R16

	// Avalon slave: every access answers on the cycle after it is seen.
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_reg        <= 1'b0;
			ctrl_reg       <= `TMQ_CTRL_RST;
			fcst_reg       <= `TMQ_FCST_RST;
			avs_readdata_o <= 32'h0;
		end else begin
			ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
			// A write lands only at the edge where waitrequest is low, when the master completes.
			if (avs_write_i && ack_reg && avs_byteenable_i[0]) begin
				case (avs_address_i)
					`TMQ_REG_CTRL: ctrl_reg <= avs_writedata_i[1:0];
					`TMQ_REG_FCST: fcst_reg <= avs_writedata_i[3:0]; // R16
					default: begin
					end
				endcase
			end
			if (avs_read_i && !ack_reg) begin
				case (avs_address_i)
					`TMQ_REG_CTRL:  avs_readdata_o <= {30'h0, ctrl_reg};
					`TMQ_REG_FCST:  avs_readdata_o <= {28'h0, fcst_reg};
					`TMQ_REG_DEPTH: avs_readdata_o <= {12'h0, tx_flow_depth_o};
					default:        avs_readdata_o <= 32'h0;
				endcase
			end
		end
	end

	a_one_ready: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R2
		$onehot0(tx_ready_o))
		else $error("more than one transmit port unstalled");
	a_full_refuse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R18
		(free_reg == 14'h0 && enq_state_reg == tmq_pkg::TMQ_ENQ_IDLE) |=>
		enq_state_reg == tmq_pkg::TMQ_ENQ_IDLE)
		else $error("packet accepted with no free slot");
	a_total_sum: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R15
		total_reg == cnt_w[0] + cnt_w[1] + cnt_w[2] + cnt_w[3])
		else $error("total depth differs from sum of queues");
	a_dq_highest: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R22
		(dq_state_reg == tmq_pkg::TMQ_DQ_IDLE && dq_any && !ctrl_reg[`TMQ_CTRL_HOLD]) |=>
		dq_state_reg == tmq_pkg::TMQ_DQ_SEND && (dq_pri_reg == 2'h3 ||
		($past(elig) >> (dq_pri_reg + 2'h1)) == 4'h0))
		else $error("dequeue skipped a higher eligible queue");
	a_retry_rewind: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R19
		(dq_state_reg == tmq_pkg::TMQ_DQ_SEND && link_retry_i) |=>
		!link_valid_o ##1 (!link_valid_o || link_sop_o))
		else $error("retry did not restart the packet");
endmodule
